/* rtl/dfd_pkg.sv */
// Purpose: Shared constants and carriers for the driver fault diagnosis block.
// Assumes: Nine output channels; six low-side drivers followed by three pre-drivers.
// Notes: Channel order is injector 1, injector 2, relay 1, relay 2, tach, lamp, heater, ignition 1, ignition 2.
package dfd_pkg;

  // ----------------------------------------------------------------
  // Channel layout
  // ----------------------------------------------------------------
  localparam int NCH = 9;
  localparam int NLSD = 6;
  localparam int TACH_CH = 4;
  localparam logic [8:0] SG_MASK = 9'h02F;
  localparam logic [8:0] OT_MASK = 9'h03F;
  localparam logic [5:0] LIMIT_MASK = 6'h2F;

  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam int AW = 5;
  localparam logic [4:0] ADDR_WDOG = 5'h0A;
  localparam logic [4:0] ADDR_SENSOR = 5'h0B;
  localparam logic [4:0] ADDR_SUPPLY = 5'h0D;
  localparam logic [4:0] ADDR_ONOFF = 5'h0E;
  localparam logic [4:0] ADDR_MODEL = 5'h0F;
  localparam logic [4:0] ADDR_ON_LO = 5'h10;
  localparam logic [4:0] ADDR_ON_HI = 5'h11;
  localparam logic [4:0] ADDR_SINK_LO = 5'h12;
  localparam logic [4:0] ADDR_SINK_HI = 5'h13;
  localparam logic [4:0] ADDR_RETRY_LO = 5'h14;
  localparam logic [4:0] ADDR_RETRY_HI = 5'h15;
  localparam logic [4:0] ADDR_GLOBAL = 5'h16;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_SUM = 7;
  localparam int BIT_OL = 3;
  localparam int BIT_OC = 2;
  localparam int BIT_OT = 1;
  localparam int BIT_SG = 0;
  localparam int SUP_SERR = 3;
  localparam int SENS_ISO_OT = 0;
  localparam int GBIT_COMBINE = 0;
  localparam int GBIT_SRST = 1;
  localparam int GBIT_POWER_ENABLE_BIT = 2;

  // ----------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------
  localparam logic [8:0] SINK_RST = 9'h1FF;
  localparam logic [2:0] GLOBAL_RST = 3'h0;
  localparam logic [7:0] MODEL_ID = 8'h5A; // Arbitrary value.
  localparam int CLK_MHZ = 100;
  localparam int RETRY_TIME_US = 10;
  localparam int RETRY_CYCLES = RETRY_TIME_US * CLK_MHZ;

  typedef struct packed {
    logic [8:0] dir_in;
    logic [8:0] oc_raw;
    logic [2:0] sense_high;
    logic [8:0] ol_raw;
    logic [5:0] sg_raw;
    logic [5:0] ot_raw;
    logic vcc_uv;
    logic vbat_ov;
    logic ignition_key_input;
    logic battery_switch_flag;
    logic serial_err;
    logic [2:0] vprot_fault;
    logic [3:0] peak;
    logic sensor_clamp_positive;
    logic sensor_clamp_negative;
    logic iso_ot;
    logic [7:0] wdog_state;
  } dfd_pins_s;

  typedef struct packed {
    logic cmd;
    logic trip;
    logic gate;
    logic ol;
    logic oc;
    logic ot;
    logic sg;
  } dfd_chan_s;

endpackage

/* rtl/dfd_top.sv */
// Purpose: Fault latching, protective switch-off and register map for nine output stages.
// Assumes: Comparator and pin levels arrive asynchronously; the register port runs on clk.
// Notes: Read data appears one cycle after reg_rd.
// Operation
// - Driver register holds summary, OL, OC, OT, SG.
// - Pre-driver registers hold summary, OL, OC only.
// - Ground-short only on injectors, relays, lamp.
// - On and output low sets ground-short.
// - Sink disabled means no ground-short flag.
// - Flags latch; write zero clears once fault gone.
// - Each low-side driver has own temperature input.
// - Overtemperature turns only that output off.
// - Output returns when temperature clears, flag stays.
// - Overcurrent checked only while output is on.
// - Drain high while on trips gate off.
// - Without retry, restart needs off then on.
// - With retry, output retries until overcurrent gone.
// - Combine bit needs serial and pin agreeing.
// - Soft reset clears device, not reset pin.
// - Undervoltage or overvoltage asserts host reset.
// - Tach shuts down rather than current-limits.
// - Supply register layout of system status bits.
// - Sensor register layout of peak, clamp, OT.
// - Off with sink enabled sets open-load flag.
// - Pre-driver feedback or sense high trips off.
`timescale 1ns/1ps
`default_nettype none
module dfd_top #(
  parameter int RETRY_CNT = dfd_pkg::RETRY_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire dfd_pkg::dfd_pins_s pins,
  input wire logic [dfd_pkg::AW-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic [dfd_pkg::NCH-1:0] gate_on,
  output logic [dfd_pkg::NCH-1:0] sink_enable,
  output logic [dfd_pkg::NLSD-1:0] curr_limit_en,
  output logic external_reset_pin_n
);
  import dfd_pkg::*;

  // The pacing counter is 20 bits wide, so longer retry periods cannot be served.
  if (RETRY_CNT < 2 || RETRY_CNT > 1000000) begin : g_bad_retry
    $error("RETRY_CNT out of range");
  end

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  dfd_pins_s pins_s1;
  dfd_pins_s p;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pins_s1 <= '0;
      p <= '0;
    end else begin
      pins_s1 <= pins;
      p <= pins_s1;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [NCH-1:0] cfg_on, next_cfg_on;
  logic [NCH-1:0] cfg_sink, next_cfg_sink;
  logic [NCH-1:0] cfg_retry, next_cfg_retry;
  logic [2:0] cfg_glob, next_cfg_glob;
  logic srst, next_srst;

  function automatic logic [NCH-1:0] wr_split(input logic [NCH-1:0] cur, input logic [AW-1:0] a,
                                              input logic [AW-1:0] lo, input logic [7:0] d);
    logic [NCH-1:0] r;
    r = cur;
    if (a == lo) begin
      r[7:0] = d;
    end else if (a == lo + 5'h01) begin
      r[NCH-1] = d[0];
    end
    return r;
  endfunction

  always_comb begin
    next_cfg_on = cfg_on;
    next_cfg_sink = cfg_sink;
    next_cfg_retry = cfg_retry;
    next_cfg_glob = cfg_glob;
    next_srst = 1'b0;
    if (srst) begin
      // Software reset brings the register file back to defaults.
      next_cfg_on = '0;
      next_cfg_sink = SINK_RST;
      next_cfg_retry = '0;
      next_cfg_glob = GLOBAL_RST;
    end else if (reg_wr) begin
      next_cfg_on = wr_split(cfg_on, reg_addr, ADDR_ON_LO, reg_wdata);
      next_cfg_sink = wr_split(cfg_sink, reg_addr, ADDR_SINK_LO, reg_wdata);
      next_cfg_retry = wr_split(cfg_retry, reg_addr, ADDR_RETRY_LO, reg_wdata);
      if (reg_addr == ADDR_GLOBAL) begin
        next_cfg_glob = {reg_wdata[GBIT_POWER_ENABLE_BIT], 1'b0, reg_wdata[GBIT_COMBINE]};
        next_srst = reg_wdata[GBIT_SRST];
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      cfg_on <= '0;
      cfg_sink <= SINK_RST;
      cfg_retry <= '0;
      cfg_glob <= GLOBAL_RST;
      srst <= 1'b0;
    end else begin
      cfg_on <= next_cfg_on;
      cfg_sink <= next_cfg_sink;
      cfg_retry <= next_cfg_retry;
      cfg_glob <= next_cfg_glob;
      srst <= next_srst;
    end
  end

  // ----------------------------------------------------------------
  // Retry pacing
  // ----------------------------------------------------------------
  // One shared tick paces every retrying channel; a shorted load is then hit
  // at most once per period rather than every cycle.
  logic [19:0] retry_cnt, next_retry_cnt;
  logic retry_tick;

  assign retry_tick = (retry_cnt == 20'(RETRY_CNT - 1));

  always_comb begin
    next_retry_cnt = retry_tick ? 20'h00000 : retry_cnt + 20'h00001;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      retry_cnt <= '0;
    end else begin
      retry_cnt <= next_retry_cnt;
    end
  end

  // ----------------------------------------------------------------
  // Per-channel protection and flags
  // ----------------------------------------------------------------
  dfd_chan_s ch_q [NCH];
  dfd_chan_s next_ch [NCH];
  logic [NCH-1:0] oc_now;
  logic [NCH-1:0] ch_sum;

  function automatic logic [AW-1:0] chan_addr(input int i);
    return (i < NLSD) ? AW'(i) : AW'(i + 1);
  endfunction

  generate
    for (genvar i = 0; i < NCH; i++) begin : g_ch
      logic ocr, otr, sgr, olr, wr_here;
      if (i >= NLSD) begin : g_pre
        assign ocr = p.oc_raw[i] | p.sense_high[i-NLSD];
        assign otr = 1'b0;
        assign sgr = 1'b0;
      end else begin : g_lsd
        assign ocr = p.oc_raw[i];
        assign otr = p.ot_raw[i] & OT_MASK[i];
        assign sgr = p.sg_raw[i] & SG_MASK[i];
      end
      assign olr = p.ol_raw[i];
      assign wr_here = reg_wr && (reg_addr == chan_addr(i));
      assign oc_now[i] = ocr;
      assign ch_sum[i] = ch_q[i].ol | ch_q[i].oc | ch_q[i].ot | ch_q[i].sg;

      always_comb begin
        next_ch[i] = ch_q[i];
        if (srst) begin
          next_ch[i] = '0;
        end else begin
          if (cfg_glob[GBIT_COMBINE]) begin
            if (cfg_on[i] == p.dir_in[i]) begin
              next_ch[i].cmd = cfg_on[i];
            end
          end else begin
            next_ch[i].cmd = cfg_on[i] | p.dir_in[i];
          end
          if (ch_q[i].gate && ocr) begin
            next_ch[i].trip = 1'b1;
          end else if (ch_q[i].trip) begin
            if (cfg_retry[i]) begin
              next_ch[i].trip = !retry_tick;
            end else begin
              next_ch[i].trip = ch_q[i].cmd || ocr;
            end
          end
          next_ch[i].gate = next_ch[i].cmd && !next_ch[i].trip && !otr;
          // Hardware set wins over a clear in the same cycle.
          next_ch[i].oc = (ch_q[i].gate && ocr) ||
                          (ch_q[i].oc && !(wr_here && !reg_wdata[BIT_OC] && !ocr));
          next_ch[i].ot = otr || (ch_q[i].ot && !(wr_here && !reg_wdata[BIT_OT]));
          next_ch[i].sg = (ch_q[i].gate && sgr && cfg_sink[i]) ||
                          (ch_q[i].sg && !(wr_here && !reg_wdata[BIT_SG] && !sgr));
          next_ch[i].ol = (!ch_q[i].gate && olr && cfg_sink[i]) ||
                          (ch_q[i].ol && !(wr_here && !reg_wdata[BIT_OL] && !olr));
        end
      end

      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          ch_q[i] <= '0;
        end else begin
          ch_q[i] <= next_ch[i];
        end
      end

      // ----------------------------------------------------------------
      // Channel checks
      // ----------------------------------------------------------------
      oc_trip_off_a: assert property (@(posedge clk) disable iff (rst || srst)
        ch_q[i].gate && ocr |=> !ch_q[i].gate && ch_q[i].oc)
        else $error("overcurrent did not switch the stage off");
      ot_stage_off_a: assert property (@(posedge clk) disable iff (rst || srst)
        otr |=> !ch_q[i].gate && ch_q[i].ot)
        else $error("overtemperature did not switch the stage off");
      sg_needs_sink_a: assert property (@(posedge clk) disable iff (rst || srst)
        $rose(ch_q[i].sg) |-> $past(cfg_sink[i]) && $past(ch_q[i].gate))
        else $error("ground-short flag set without sink");
      flag_held_a: assert property (@(posedge clk) disable iff (rst || srst)
        ch_q[i].oc && ocr |=> ch_q[i].oc)
        else $error("overcurrent flag cleared while fault present");
      no_restart_a: assert property (@(posedge clk) disable iff (rst || srst)
        ch_q[i].trip && !cfg_retry[i] && ch_q[i].cmd && $stable(cfg_retry[i]) |=> !ch_q[i].gate)
        else $error("stage restarted without off command");
      ot_return_a: assert property (@(posedge clk) disable iff (rst || srst)
        ch_q[i].ot && !otr && !ch_q[i].trip && !ocr && next_ch[i].cmd |=> ch_q[i].gate)
        else $error("stage did not return after overtemperature");
    end
  endgenerate

  tach_no_sg_a: assert property (@(posedge clk) disable iff (rst)
    !ch_q[TACH_CH].sg && !ch_q[NLSD].ot && !ch_q[NLSD].sg)
    else $error("unsupported flag set");

  // ----------------------------------------------------------------
  // System flags and host reset
  // ----------------------------------------------------------------
  logic fl_serr, next_fl_serr;
  logic [2:0] fl_vprot, next_fl_vprot;
  logic fl_iso, next_fl_iso;
  logic rst_n_q, next_rst_n_q;
  logic wr_sup, wr_sens;

  assign wr_sup = reg_wr && (reg_addr == ADDR_SUPPLY);
  assign wr_sens = reg_wr && (reg_addr == ADDR_SENSOR);

  always_comb begin
    next_rst_n_q = !(p.vcc_uv || p.vbat_ov);
    if (srst) begin
      next_fl_serr = 1'b0;
      next_fl_vprot = '0;
      next_fl_iso = 1'b0;
    end else begin
      next_fl_serr = p.serial_err || (fl_serr && !(wr_sup && !reg_wdata[SUP_SERR]));
      next_fl_vprot = p.vprot_fault | (fl_vprot & ~({3{wr_sup}} & ~reg_wdata[2:0]));
      next_fl_iso = p.iso_ot || (fl_iso && !(wr_sens && !reg_wdata[SENS_ISO_OT]));
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fl_serr <= 1'b0;
      fl_vprot <= '0;
      fl_iso <= 1'b0;
      rst_n_q <= 1'b0;
    end else begin
      fl_serr <= next_fl_serr;
      fl_vprot <= next_fl_vprot;
      fl_iso <= next_fl_iso;
      rst_n_q <= next_rst_n_q;
    end
  end

  ext_reset_a: assert property (@(posedge clk) disable iff (rst)
    p.vcc_uv || p.vbat_ov |-> ##2 !external_reset_pin_n)
    else $error("supply fault did not assert host reset");
  soft_reset_a: assert property (@(posedge clk) disable iff (rst)
    srst |=> $stable(external_reset_pin_n) && ch_sum == '0 && cfg_on == '0)
    else $error("soft reset did not clear state or moved reset pin");

  // ----------------------------------------------------------------
  // Read path and outputs
  // ----------------------------------------------------------------
  logic [7:0] rd_val, next_rdata;
  logic any_fault;
  logic [NCH-1:0] g;

  always_comb begin
    for (int k = 0; k < NCH; k++) begin
      g[k] = ch_q[k].gate;
    end
  end

  assign any_fault = (|ch_sum) | fl_serr | (|fl_vprot) | fl_iso;

  always_comb begin
    rd_val = 8'h00;
    for (int k = 0; k < NCH; k++) begin
      if (reg_addr == chan_addr(k)) begin
        rd_val[BIT_SUM] = ch_sum[k];
        rd_val[BIT_OL] = ch_q[k].ol;
        rd_val[BIT_OC] = ch_q[k].oc;
        rd_val[BIT_OT] = ch_q[k].ot;
        rd_val[BIT_SG] = ch_q[k].sg;
      end
    end
    unique case (reg_addr)
      ADDR_WDOG: rd_val = p.wdog_state;
      ADDR_SENSOR: rd_val = {p.peak, 1'b0, p.sensor_clamp_positive, p.sensor_clamp_negative, fl_iso};
      ADDR_SUPPLY: rd_val = {any_fault, p.ignition_key_input, cfg_glob[GBIT_POWER_ENABLE_BIT],
                             p.battery_switch_flag, fl_serr, fl_vprot};
      ADDR_ONOFF: rd_val = {g[0], g[1], g[2], g[3], g[5], g[7], g[8], g[6]};
      ADDR_MODEL: rd_val = MODEL_ID;
      ADDR_ON_LO: rd_val = cfg_on[7:0];
      ADDR_ON_HI: rd_val = {7'h00, cfg_on[NCH-1]};
      ADDR_SINK_LO: rd_val = cfg_sink[7:0];
      ADDR_SINK_HI: rd_val = {7'h00, cfg_sink[NCH-1]};
      ADDR_RETRY_LO: rd_val = cfg_retry[7:0];
      ADDR_RETRY_HI: rd_val = {7'h00, cfg_retry[NCH-1]};
      ADDR_GLOBAL: rd_val = {5'h00, cfg_glob};
      default: ;
    endcase
    next_rdata = reg_rd ? rd_val : 8'h00;
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
      gate_on <= '0;
      sink_enable <= '0;
      curr_limit_en <= '0;
      external_reset_pin_n <= 1'b0;
    end else begin
      reg_rdata <= next_rdata;
      gate_on <= g;
      sink_enable <= cfg_sink;
      curr_limit_en <= LIMIT_MASK;
      external_reset_pin_n <= rst_n_q;
    end
  end

  sum_read_a: assert property (@(posedge clk) disable iff (rst)
    reg_rd && reg_addr == 5'h00 |=> reg_rdata[BIT_SUM] == $past(ch_sum[0]))
    else $error("summary bit does not match flags");
  gate_follow_a: assert property (@(posedge clk) disable iff (rst)
    ##1 gate_on == $past(g))
    else $error("gate output does not follow stage state");

  oc_trip_c: cover property (@(posedge clk) disable iff (rst) $rose(ch_q[0].trip));
  retry_on_c: cover property (@(posedge clk) disable iff (rst)
    ch_q[2].trip && cfg_retry[2] ##1 ch_q[2].gate);
  combine_c: cover property (@(posedge clk) disable iff (rst)
    cfg_glob[GBIT_COMBINE] && cfg_on[1] != p.dir_in[1]);
  soft_rst_c: cover property (@(posedge clk) disable iff (rst) srst);
endmodule
`default_nettype wire

/* verification/dfd_load_model.sv */
// Purpose: Behavioural model of the loads and comparators on the far side of the nine output stages.
// Assumes: Fault knobs come from the bench; the gate state comes from the design.
// Notes: Comparators only report what the load would show in the present gate state.
`timescale 1ns/1ps
`default_nettype none
module dfd_load_model (
  input wire logic [dfd_pkg::NCH-1:0] gate_on,
  input wire logic [dfd_pkg::NCH-1:0] sink_enable,
  input wire logic [dfd_pkg::NCH-1:0] short_bat,
  input wire logic [dfd_pkg::NLSD-1:0] short_gnd,
  input wire logic [dfd_pkg::NCH-1:0] open_load,
  input wire logic [dfd_pkg::NLSD-1:0] hot,
  output logic [dfd_pkg::NCH-1:0] oc_raw,
  output logic [dfd_pkg::NLSD-1:0] sg_raw,
  output logic [dfd_pkg::NCH-1:0] ol_raw,
  output logic [dfd_pkg::NLSD-1:0] ot_raw
);
  import dfd_pkg::*;
  // ----------------------------------------------------------------
  // Comparator levels
  // ----------------------------------------------------------------
  // A short to battery only lifts the drain while the stage conducts.
  assign oc_raw = gate_on & short_bat;
  // A parallel short to ground pulls the on-state output under the reference.
  assign sg_raw = gate_on[NLSD-1:0] & short_gnd;
  // Without the pull-down sink a missing load cannot be seen at all.
  assign ol_raw = ~gate_on & open_load & sink_enable;
  // The sensor hysteresis is modelled by the bench releasing the knob.
  assign ot_raw = hot;
endmodule
`default_nettype wire

/* verification/driver_fault_diagnosis_bench.sv */
// Purpose: Self-checking bench for the fault latching, switch-off and register map of dfd_top.
// Assumes: Retry tick shortened to 4 cycles; register reads answer one cycle after the request.
// Notes: Plain register reads sit in a table; protection sequences are written out below it.
`timescale 1ns/1ps
`default_nettype none
module driver_fault_diagnosis_bench;
  import dfd_pkg::*;
  logic clk, rst, reg_wr, reg_rd, external_reset_pin_n;
  logic [AW-1:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, rv;
  logic [NCH-1:0] gate_on, sink_enable, short_bat, open_load, oc_raw, ol_raw;
  logic [NLSD-1:0] curr_limit_en, short_gnd, hot, sg_raw, ot_raw;
  dfd_pins_s pins, pins_b;
  int miscompares = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rises;
  logic [12:0] rows [11] = '{{5'h00, 8'h00}, {5'h04, 8'h00}, {5'h06, 8'h00}, {5'h09, 8'h00}, {5'h0A, 8'hA5},
    {5'h0B, 8'h94}, {5'h0C, 8'h00}, {5'h0D, 8'h50}, {5'h0E, 8'h00}, {5'h0F, MODEL_ID}, {5'h1F, 8'h00}};
  // ----------------------------------------------------------------
  // Design, load model and clock
  // ----------------------------------------------------------------
  dfd_top #(.RETRY_CNT(4)) u_dfd_top (.clk(clk), .rst(rst), .pins(pins), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .gate_on(gate_on), .sink_enable(sink_enable),
    .curr_limit_en(curr_limit_en), .external_reset_pin_n(external_reset_pin_n));
  dfd_load_model u_dfd_load_model (.gate_on(gate_on), .sink_enable(sink_enable), .short_bat(short_bat),
    .short_gnd(short_gnd), .open_load(open_load), .hot(hot), .oc_raw(oc_raw), .sg_raw(sg_raw), .ol_raw(ol_raw),
    .ot_raw(ot_raw));
  always_comb begin
    pins = pins_b;
    pins.oc_raw = oc_raw;
    pins.sg_raw = sg_raw;
    pins.ol_raw = ol_raw;
    pins.ot_raw = ot_raw;
  end
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // The whole run needs under 400 cycles; the ceiling leaves wide margin.
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      test_done();
    end
  end
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic test_done();
    if (miscompares == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rchk(input logic [4:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), {8'h00, e}, {8'h00, reg_rdata});
  endtask
  function automatic logic sel(input int ch);
    return (ch < 0) ? external_reset_pin_n : gate_on[ch];
  endfunction
  // A channel of -1 watches the host reset pin instead of a gate.
  task automatic wgate(input int ch, input logic v, input int n);
    int i;
    i = 0;
    while (sel(ch) !== v && i < n) begin
      @(posedge clk);
      #1;
      i++;
    end
    chk($sformatf("gate %0d", ch), {15'h0, v}, {15'h0, sel(ch)});
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    {short_bat, short_gnd, open_load, hot} = '0;
    pins_b = '0;
    pins_b.ignition_key_input = 1'b1;
    pins_b.battery_switch_flag = 1'b1;
    pins_b.peak = 4'h9;
    pins_b.sensor_clamp_positive = 1'b1;
    pins_b.wdog_state = 8'hA5;
    settle(5);
    chk("reset outputs", 16'h0, {6'h0, external_reset_pin_n, gate_on});
    @(posedge clk) rst <= 1'b0;
    wgate(-1, 1'b1, 6);
    for (int r = 0; r < 11; r++)
      rchk(rows[r][12:8], rows[r][7:0]);
    chk("current limit", 16'h002F, {10'h0, curr_limit_en});
    // Overcurrent without retry on injector 1.
    wr(5'h10, 8'h01);
    wgate(0, 1'b1, 6);
    @(posedge clk) short_bat[0] <= 1'b1;
    wgate(0, 1'b0, 8);
    rchk(5'h00, 8'h84);
    wr(5'h00, 8'h00);
    // The tripped stage no longer conducts, so its comparator sees no fault and the clear is taken.
    rchk(5'h00, 8'h00);
    @(posedge clk) short_bat[0] <= 1'b0;
    settle(10);
    chk("no restart", 16'h0, {15'h0, gate_on[0]});
    wr(5'h00, 8'h00);
    rchk(5'h00, 8'h00);
    wr(5'h10, 8'h00);
    wr(5'h10, 8'h01);
    wgate(0, 1'b1, 6);
    // Overcurrent with retry on relay 1.
    wr(5'h14, 8'h04);
    wr(5'h10, 8'h05);
    wgate(2, 1'b1, 6);
    @(posedge clk) short_bat[2] <= 1'b1;
    rises = 0;
    for (int i = 0; i < 80; i++) begin
      rv[0] = gate_on[2];
      settle(1);
      if (!rv[0] && gate_on[2] === 1'b1)
        rises++;
    end
    chk("retry attempts", 16'h1, {15'h0, rises >= 2});
    rchk(5'h02, 8'h84);
    @(posedge clk) short_bat[2] <= 1'b0;
    wgate(2, 1'b1, 20);
    // Overtemperature on relay 2 with the lamp running beside it.
    wr(5'h10, 8'h28);
    wgate(3, 1'b1, 6);
    wgate(5, 1'b1, 6);
    @(posedge clk) hot[3] <= 1'b1;
    wgate(3, 1'b0, 6);
    chk("lamp unaffected", 16'h1, {15'h0, gate_on[5]});
    rchk(5'h03, 8'h82);
    wr(5'h03, 8'h00);
    rchk(5'h03, 8'h82);
    @(posedge clk) hot[3] <= 1'b0;
    wgate(3, 1'b1, 6);
    rchk(5'h03, 8'h82);
    wr(5'h03, 8'h00);
    rchk(5'h03, 8'h00);
    // Ground short: lamp flags, tach has none, disabled sink blocks it.
    @(posedge clk) short_gnd <= 6'h31;
    settle(6);
    rchk(5'h05, 8'h81);
    wr(5'h12, 8'hFE);
    wr(5'h10, 8'h11);
    wgate(4, 1'b1, 6);
    settle(6);
    rchk(5'h04, 8'h00);
    rchk(5'h00, 8'h00);
    @(posedge clk) short_gnd <= '0;
    // Pre-driver open load and sense trip.
    @(posedge clk) open_load[6] <= 1'b1;
    settle(6);
    rchk(5'h07, 8'h88);
    wr(5'h10, 8'h80);
    wgate(7, 1'b1, 6);
    @(posedge clk) pins_b.sense_high[1] <= 1'b1;
    wgate(7, 1'b0, 8);
    rchk(5'h08, 8'h84);
    // Combined serial and direct switching on injector 2.
    wr(5'h10, 8'h00);
    wr(5'h16, 8'h01);
    @(posedge clk) pins_b.dir_in[1] <= 1'b1;
    settle(8);
    chk("combine off", 16'h0, {15'h0, gate_on[1]});
    wr(5'h10, 8'h02);
    wgate(1, 1'b1, 8);
    @(posedge clk) pins_b.dir_in[1] <= 1'b0;
    settle(8);
    chk("combine hold", 16'h1, {15'h0, gate_on[1]});
    // Soft reset clears latched flags but leaves the host reset pin alone.
    @(posedge clk) {open_load, pins_b.sense_high} <= '0;
    wr(5'h16, 8'h02);
    rises = 0;
    for (int i = 0; i < 10; i++) begin
      settle(1);
      if (external_reset_pin_n !== 1'b1)
        rises++;
    end
    chk("pin during soft reset", 16'h0, rises[15:0]);
    chk("gates after soft reset", 16'h0, {7'h0, gate_on});
    rchk(5'h07, 8'h00);
    // Supply faults raise the host reset.
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) {pins_b.vcc_uv, pins_b.vbat_ov} <= (k == 0) ? 2'b10 : 2'b01;
      wgate(-1, 1'b0, 8);
      @(posedge clk) {pins_b.vcc_uv, pins_b.vbat_ov} <= 2'b00;
      wgate(-1, 1'b1, 8);
    end
    test_done();
  end
endmodule
`default_nettype wire
